//--- core/tsm_consts.vh
`ifndef TSM_CONSTS_VH
`define TSM_CONSTS_VH

// Controller state codes
`define TSM_ST_EXIT2_DR   4'h0
`define TSM_ST_EXIT1_DR   4'h1
`define TSM_ST_SHIFT_DR   4'h2
`define TSM_ST_PAUSE_DR   4'h3
`define TSM_ST_SELECT_IR  4'h4
`define TSM_ST_UPDATE_DR  4'h5
`define TSM_ST_CAPTURE_DR 4'h6
`define TSM_ST_SELECT_DR  4'h7
`define TSM_ST_EXIT2_IR   4'h8
`define TSM_ST_EXIT1_IR   4'h9
`define TSM_ST_SHIFT_IR   4'hA
`define TSM_ST_PAUSE_IR   4'hB
`define TSM_ST_RUN_IDLE   4'hC
`define TSM_ST_UPDATE_IR  4'hD
`define TSM_ST_CAPTURE_IR 4'hE
`define TSM_ST_RESET      4'hF

// Instruction register geometry and opcodes (opcode values are arbitrary)
`define TSM_IR_W          4
`define TSM_OP_IDCODE     4'h2
`define TSM_OP_LINK_SEL   4'h5
`define TSM_OP_DBG_EN     4'h6
`define TSM_OP_BYPASS     4'hF

// Instruction capture pattern in the low bits, status above
`define TSM_IR_CAP_LOW    2'h1
`define TSM_STATUS_W      2

// Identification word (arbitrary value, bit 0 must be one)
`define TSM_IDCODE_W      32
`define TSM_IDCODE_VAL    32'h00000001

// Linking register: bit 0 master port, bit 1 core debug port
`define TSM_LINK_W        4
`define TSM_LINK_RST      4'h1
`define TSM_LINK_MASTER   0
`define TSM_LINK_CORE     1

`endif

//--- core/tsm_sync.v
`timescale 1ns/1ps
`default_nettype none

module tsm_sync #(
  parameter W = 3
) (
  // Clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // Levels from outside the domain
  input  wire [W-1:0] d,
  output reg  [W-1:0] q
);

  reg [W-1:0] meta;

  // Two flops; only the second stage is read outside
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      meta <= {W{1'b0}};
      q    <= {W{1'b0}};
    end else begin
      meta <= d;
      q    <= meta;
    end
  end

endmodule

`default_nettype wire

//--- core/tsm_shift_reg.v
`timescale 1ns/1ps
`default_nettype none

module tsm_shift_reg #(
  parameter         W   = 4,
  parameter [W-1:0] RST = {W{1'b0}}
) (
  // Clock and reset
  input  wire         clk,
  input  wire         arst_n,
  // Stage controls; capture, shift and update are one-cycle strobes, preset may be a level
  input  wire         preset,
  input  wire         capture,
  input  wire         shift,
  input  wire         update,
  // Data
  input  wire [W-1:0] par_in,
  input  wire         ser_in,
  output wire         ser_out,
  output reg  [W-1:0] par_out
);

  reg  [W-1:0] shift_q;
  wire [W:0]   cat = {ser_in, shift_q};

  assign ser_out = shift_q[0];

  // Shift stage: capture wins over shift, LSB leaves first
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shift_q <= RST;
    end else if (capture) begin
      shift_q <= par_in;
    end else if (shift) begin
      shift_q <= cat[W:1];
    end
  end

  // Parallel output stage, isolated from the shifting
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      par_out <= RST;
    end else if (preset) begin
      par_out <= RST;
    end else if (update) begin
      par_out <= shift_q;
    end
  end

endmodule

`default_nettype wire

//--- core/tsm_tap.v
`timescale 1ns/1ps
`include "tsm_consts.vh"
`default_nettype none

module tsm_tap #(
  parameter                      IR_W     = `TSM_IR_W,
  parameter                      LINK_W   = `TSM_LINK_W,
  parameter                      ID_W     = `TSM_IDCODE_W,
  parameter [ID_W-1:0]           ID_VAL   = `TSM_IDCODE_VAL,
  parameter                      STATUS_W = `TSM_STATUS_W
) (
  // Clock and reset
  input  wire                core_clk,
  input  wire                nrst,
  // Test port pins
  input  wire                tck,
  input  wire                tms,
  input  wire                tdi,
  input  wire                trst_n,
  output wire                tdo,
  output wire                tdo_oe_n,
  // Device status seen in instruction capture
  input  wire [STATUS_W-1:0] sys_status,
  // Controller view
  output wire [3:0]          tap_state,
  output wire [IR_W-1:0]     instr,
  output wire                test_logic_reset,
  // Linking register outputs
  output wire                link_master_en,
  output wire                link_core_en,
  // Debug module scan path
  output wire                dbg_capture,
  output wire                dbg_shift,
  output wire                dbg_update,
  output wire                dbg_tdi,
  input  wire                dbg_tdo
);

  // Pin reset and system reset share the asynchronous net
  wire       arst_raw_n = nrst & trst_n;
  reg  [1:0] rst_hold;

  // Assert at once, release two clocks later so no flop sees a ragged edge
  always @(posedge core_clk or negedge arst_raw_n) begin
    if (!arst_raw_n) begin
      rst_hold <= 2'h0;
    end else begin
      rst_hold <= {rst_hold[0], 1'b1};
    end
  end

  wire arst_n = rst_hold[1];

  // Next-state function of the sixteen-state machine
  function [3:0] tsm_next;
    input [3:0] st;
    input       m;
    begin
      case (st)
        `TSM_ST_RESET:      tsm_next = m ? `TSM_ST_RESET : `TSM_ST_RUN_IDLE;
        `TSM_ST_RUN_IDLE:   tsm_next = m ? `TSM_ST_SELECT_DR : `TSM_ST_RUN_IDLE;
        `TSM_ST_SELECT_DR:  tsm_next = m ? `TSM_ST_SELECT_IR : `TSM_ST_CAPTURE_DR;
        `TSM_ST_SELECT_IR:  tsm_next = m ? `TSM_ST_RESET : `TSM_ST_CAPTURE_IR;
        `TSM_ST_CAPTURE_DR: tsm_next = m ? `TSM_ST_EXIT1_DR : `TSM_ST_SHIFT_DR;
        `TSM_ST_SHIFT_DR:   tsm_next = m ? `TSM_ST_EXIT1_DR : `TSM_ST_SHIFT_DR;
        `TSM_ST_EXIT1_DR:   tsm_next = m ? `TSM_ST_UPDATE_DR : `TSM_ST_PAUSE_DR;
        `TSM_ST_PAUSE_DR:   tsm_next = m ? `TSM_ST_EXIT2_DR : `TSM_ST_PAUSE_DR;
        `TSM_ST_EXIT2_DR:   tsm_next = m ? `TSM_ST_UPDATE_DR : `TSM_ST_SHIFT_DR;
        `TSM_ST_UPDATE_DR:  tsm_next = m ? `TSM_ST_SELECT_DR : `TSM_ST_RUN_IDLE;
        `TSM_ST_CAPTURE_IR: tsm_next = m ? `TSM_ST_EXIT1_IR : `TSM_ST_SHIFT_IR;
        `TSM_ST_SHIFT_IR:   tsm_next = m ? `TSM_ST_EXIT1_IR : `TSM_ST_SHIFT_IR;
        `TSM_ST_EXIT1_IR:   tsm_next = m ? `TSM_ST_UPDATE_IR : `TSM_ST_PAUSE_IR;
        `TSM_ST_PAUSE_IR:   tsm_next = m ? `TSM_ST_EXIT2_IR : `TSM_ST_PAUSE_IR;
        `TSM_ST_EXIT2_IR:   tsm_next = m ? `TSM_ST_UPDATE_IR : `TSM_ST_SHIFT_IR;
        `TSM_ST_UPDATE_IR:  tsm_next = m ? `TSM_ST_SELECT_IR : `TSM_ST_RUN_IDLE;
        default:            tsm_next = `TSM_ST_RESET;
      endcase
    end
  endfunction

  // Pins synchronised to core_clk; test clock must be well below core rate
  wire [2:0] pin_s;

  tsm_sync #(
    .W      (3)
  ) u_pin_sync (
    .clk    (core_clk),
    .arst_n (arst_n),
    .d      ({tck, tms, tdi}),
    .q      (pin_s)
  );

  wire tck_s = pin_s[2];
  wire tms_s = pin_s[1];
  wire tdi_s = pin_s[0];

  reg  tck_d;
  wire tck_rise = tck_s & ~tck_d;
  wire tck_fall = ~tck_s & tck_d;

  // Previous test clock level for edge detection
  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tck_d <= 1'b0;
    end else begin
      tck_d <= tck_s;
    end
  end

  // Controller state register
  reg  [3:0] state;
  wire [3:0] next_state = tsm_next(state, tms_s);

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= `TSM_ST_RESET;
    end else if (tck_rise) begin
      state <= next_state;
    end
  end

  // State decodes
  wire in_reset   = (state == `TSM_ST_RESET);
  wire in_cap_dr  = (state == `TSM_ST_CAPTURE_DR);
  wire in_shf_dr  = (state == `TSM_ST_SHIFT_DR);
  wire in_upd_dr  = (state == `TSM_ST_UPDATE_DR);
  wire in_cap_ir  = (state == `TSM_ST_CAPTURE_IR);
  wire in_shf_ir  = (state == `TSM_ST_SHIFT_IR);
  wire in_upd_ir  = (state == `TSM_ST_UPDATE_IR);

  // Capture and shift on the rising edge; update on the falling edge
  wire cap_dr = tck_rise & in_cap_dr;
  wire shf_dr = tck_rise & in_shf_dr;
  wire upd_dr = tck_fall & in_upd_dr;
  wire cap_ir = tck_rise & in_cap_ir;
  wire shf_ir = tck_rise & in_shf_ir;
  wire upd_ir = tck_fall & in_upd_ir;

  // Instruction register; reset state forces the identification opcode
  wire [IR_W-1:0] ir_cap = {sys_status, `TSM_IR_CAP_LOW};
  wire            ir_so;

  tsm_shift_reg #(
    .W       (IR_W),
    .RST     (`TSM_OP_IDCODE)
  ) u_ir (
    .clk     (core_clk),
    .arst_n  (arst_n),
    .preset  (in_reset),
    .capture (cap_ir),
    .shift   (shf_ir),
    .update  (upd_ir),
    .par_in  (ir_cap),
    .ser_in  (tdi_s),
    .ser_out (ir_so),
    .par_out (instr)
  );

  // Data register selection by the current instruction, and for debug also by link_core_en
  wire sel_id    = (instr == `TSM_OP_IDCODE);
  wire sel_link  = (instr == `TSM_OP_LINK_SEL);
  wire sel_dbg   = (instr == `TSM_OP_DBG_EN) & link_core_en;
  wire sel_byp   = ~sel_id & ~sel_link & ~sel_dbg;

  // Identification register, capture only
  wire id_so;

  tsm_shift_reg #(
    .W       (ID_W),
    .RST     (ID_VAL)
  ) u_id (
    .clk     (core_clk),
    .arst_n  (arst_n),
    .preset  (1'b0),
    .capture (cap_dr & sel_id),
    .shift   (shf_dr & sel_id),
    .update  (1'b0),
    .par_in  (ID_VAL),
    .ser_in  (tdi_s),
    .ser_out (id_so),
    .par_out ()
  );

  // Linking register: parallel input is a registered copy of its own output, so capture reads back the link bits
  wire [LINK_W-1:0] link_q;
  wire              link_so;
  reg  [LINK_W-1:0] link_keep;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      link_keep <= `TSM_LINK_RST;
    end else begin
      link_keep <= link_q;
    end
  end

  tsm_shift_reg #(
    .W       (LINK_W),
    .RST     (`TSM_LINK_RST)
  ) u_link (
    .clk     (core_clk),
    .arst_n  (arst_n),
    .preset  (in_reset),
    .capture (cap_dr & sel_link),
    .shift   (shf_dr & sel_link),
    .update  (upd_dr & sel_link),
    .par_in  (link_keep),
    .ser_in  (tdi_s),
    .ser_out (link_so),
    .par_out (link_q)
  );

  assign link_master_en = link_q[`TSM_LINK_MASTER];
  assign link_core_en   = link_q[`TSM_LINK_CORE];

  // Single-bit bypass, captures zero
  wire byp_so;

  tsm_shift_reg #(
    .W       (1),
    .RST     (1'b0)
  ) u_byp (
    .clk     (core_clk),
    .arst_n  (arst_n),
    .preset  (1'b0),
    .capture (cap_dr & sel_byp),
    .shift   (shf_dr & sel_byp),
    .update  (1'b0),
    .par_in  (1'b0),
    .ser_in  (tdi_s),
    .ser_out (byp_so),
    .par_out ()
  );

  // Debug module scan strobes pass through on the same clock
  assign dbg_capture = cap_dr & sel_dbg;
  assign dbg_shift   = shf_dr & sel_dbg;
  assign dbg_update  = upd_dr & sel_dbg;
  assign dbg_tdi     = tdi_s;

  // Serial output multiplexer
  reg dr_so;

  always @* begin
    if (sel_id) begin
      dr_so = id_so;
    end else if (sel_link) begin
      dr_so = link_so;
    end else if (sel_dbg) begin
      dr_so = dbg_tdo;
    end else begin
      dr_so = byp_so;
    end
  end

  // Output pin registered on the falling edge, so it is stable at rise
  reg tdo_q;
  reg tdo_oe_q;

  always @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      tdo_q    <= 1'b0;
      tdo_oe_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q    <= in_shf_ir ? ir_so : dr_so;
      tdo_oe_q <= ~(in_shf_ir | in_shf_dr);
    end
  end

  assign tdo              = tdo_q;
  assign tdo_oe_n         = tdo_oe_q;
  assign tap_state        = state;
  assign test_logic_reset = in_reset;

endmodule

`default_nettype wire

//--- verification/tsm_tap_asserts.sv
`timescale 1ns/1ps
`default_nettype none
module tsm_tap_asserts (
  // Clock and resets
  input wire logic       core_clk,
  input wire logic       nrst,
  input wire logic       trst_n,
  // Test pins
  input wire logic       tck,
  input wire logic       tms,
  input wire logic       tdo,
  input wire logic       tdo_oe_n,
  // Controller view
  input wire logic [3:0] tap_state,
  input wire logic [3:0] instr,
  input wire logic       test_logic_reset,
  input wire logic       link_core_en
);
  logic [5:0] tck_hist;
  // Either reset line clears the controller, so both mute the checks except AST_TRST, which only nrst mutes
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!nrst || !trst_n);
  // Recent test clock samples, to tell quiet spans from edges
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) tck_hist <= 6'h00;
    else tck_hist <= {tck_hist[4:0], tck};
  end
  AST_STILL_CLOCK: assert property (tck_hist == {6{tck}} |-> $stable(tap_state))
    else $error("state moved with the test clock still");
  AST_TDO_ON_FALL: assert property ($changed(tdo) || $changed(tdo_oe_n) |->
    !tck && tck_hist[2:0] == 3'h0) else $error("serial out moved away from a fall");
  AST_OE_ON: assert property ($fell(tdo_oe_n) |-> tap_state inside {4'h2, 4'hA})
    else $error("serial out enabled outside shift");
  AST_OE_HOLD: assert property (!tdo_oe_n |-> tap_state inside {4'h1, 4'h2, 4'h9, 4'hA})
    else $error("serial out driven in a wrong state");
  AST_INSTR_HOLD: assert property ($changed(instr) |-> tap_state inside {4'hD, 4'hF})
    else $error("instruction changed outside update or reset");
  AST_TRST: assert property (disable iff (!nrst) !trst_n |-> tap_state == 4'hF && instr == 4'h2)
    else $error("test reset did not force reset state");
  AST_IDCODE: assert property (tap_state == 4'hF && $past(tap_state) == 4'hF |-> instr == 4'h2)
    else $error("reset state without identification instruction");
  AST_TLR_FLAG: assert property (test_logic_reset == (tap_state == 4'hF))
    else $error("reset flag disagrees with state");
  AST_IDLE_LEAVE: assert property ($changed(tap_state) && $past(tap_state) == 4'hC |->
    tap_state == 4'h7 && tms) else $error("bad exit from idle");
  AST_SELECT_IR: assert property ($changed(tap_state) && $past(tap_state) == 4'h4 |->
    tap_state == (tms ? 4'hF : 4'hE)) else $error("bad exit from select instruction");
  // The reset state presets the link register as well
  AST_LINK_UPDATE: assert property ($changed(link_core_en) |->
    (tap_state == 4'h5 && instr == 4'h5 && !tck) || tap_state == 4'hF)
    else $error("link changed outside update or reset");
endmodule
bind tsm_tap tsm_tap_asserts tsm_tap_asserts_i (.core_clk(core_clk), .nrst(nrst),
  .trst_n(trst_n), .tck(tck), .tms(tms), .tdo(tdo), .tdo_oe_n(tdo_oe_n),
  .tap_state(tap_state), .instr(instr), .test_logic_reset(test_logic_reset),
  .link_core_en(link_core_en));
`default_nettype wire

//--- verification/tsm_probe.sv
`timescale 1ns/1ps
`default_nettype none
module tsm_probe (
  // Clock used to pace the pins
  input  wire logic core_clk,
  // Test port pins
  output var  logic tck,
  output var  logic tms,
  output var  logic tdi,
  output var  logic trst_n,
  input  wire logic tdo
);
  // Pins idle at the pull-up level, test clock parked low
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b1;
    trst_n = 1'b1;
  end
  // Waits n clock edges, then steps just past the last one
  task automatic hold(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  // One 32 ns test clock; tdo taken late in the high phase, before the fall
  task automatic step(input logic m, input logic d, output logic o);
    tms = m;
    tdi = d;
    hold(4);
    tck = 1'b1;
    hold(4);
    o = tdo;
    tck = 1'b0;
  endtask
  // Five high mode-select edges reach reset from anywhere
  task automatic reset5;
    logic o;
    repeat (5) step(1'b1, 1'b1, o);
  endtask
endmodule
`default_nettype wire

//--- verification/tap_state_machine_tb_top.sv
`timescale 1ns/1ps
`include "tsm_consts.vh"
`default_nettype none
module tap_state_machine_tb_top;
  logic        core_clk;
  logic        nrst;
  logic        tck, tms, tdi, trst_n, tdo, tdo_oe_n, tlr, lm, lc, dbg_tdo, q;
  logic [1:0]  sys_status;
  logic [3:0]  tap_state;
  logic [3:0]  instr;
  logic [31:0] word;
  int          err_total;
  int          compares;
  logic        dbg_cap, dbg_shf, dbg_upd, dbg_in;
  logic [3:0]  dbg_seen;
  int          dbg_caps = 0;
  int          dbg_shifts = 0;
  int          dbg_upds = 0;
  // Debug path output held at one so its scan reads back all ones
  tsm_tap tsm_tap_i (
    .core_clk(core_clk), .nrst(nrst), .tck(tck), .tms(tms), .tdi(tdi), .trst_n(trst_n),
    .tdo(tdo), .tdo_oe_n(tdo_oe_n), .sys_status(sys_status), .tap_state(tap_state),
    .instr(instr), .test_logic_reset(tlr), .link_master_en(lm), .link_core_en(lc),
    .dbg_capture(dbg_cap), .dbg_shift(dbg_shf), .dbg_update(dbg_upd), .dbg_tdi(dbg_in),
    .dbg_tdo(dbg_tdo));
  // Released serial out shows the inverse of its last value, so a late enable is seen
  tsm_probe probe_i (.core_clk(core_clk), .tck(tck), .tms(tms), .tdi(tdi),
    .trst_n(trst_n), .tdo(tdo_oe_n ? ~tdo : tdo));
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // Debug strobes counted, debug serial bits gathered first bit lowest
  always @(posedge core_clk) begin
    if (dbg_cap) dbg_caps <= dbg_caps + 1;
    if (dbg_shf) dbg_shifts <= dbg_shifts + 1;
    if (dbg_upd) dbg_upds <= dbg_upds + 1;
    if (dbg_shf) dbg_seen <= {dbg_in, dbg_seen[3:1]};
  end
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Walks a tms pattern, lowest bit first
  task automatic walk(input logic [7:0] pat, input int n);
    for (int i = 0; i < n; i++) probe_i.step(pat[i], 1'b1, q);
  endtask
  // Shifts n bits lowest first, leaves via update to idle
  task automatic scan(input logic [31:0] d, input int n, output logic [31:0] o);
    o = 32'h0;
    for (int i = 0; i < n; i++) begin
      probe_i.step(i == n - 1, d[i], q);
      o[i] = q;
    end
    walk(8'h01, 2);
  endtask
  task automatic t_reset;
    check("reset state", tap_state, 4'hF);
    check("reset instr", instr, `TSM_OP_IDCODE);
    check("reset flags", {tlr, tdo_oe_n, lm, lc}, 4'hE);
  endtask
  // Every arc but Exit2-DR to Update-DR at least once; tms table and state codes listed first step first
  task automatic t_arcs;
    logic [43:0]  m;
    logic [163:0] s;
    logic [3:0]   prev;
    m = 44'h1225DB49CB7;
    s = 164'hFCC762213302157615C74E9BB8AA9D4EA9B8DC74F;
    probe_i.reset5();
    prev = 4'hF;
    for (int i = 0; i < 41; i++) begin
      probe_i.step(m[40 - i], 1'b1, q);
      check("oe_n", tdo_oe_n, !(prev == 4'h2 || prev == 4'hA));
      prev = s[163 - 4 * i -: 4];
      check("state", tap_state, prev);
    end
    probe_i.hold(20);
    check("still", tap_state, 4'hF);
  endtask
  task automatic t_idcode;
    walk(8'h02, 4);
    scan(32'h0, 32, word);
    check("idcode", word, `TSM_IDCODE_VAL);
    check("instr kept", instr, `TSM_OP_IDCODE);
  endtask
  // Link select, link write, debug enable, debug scan in that order
  task automatic t_link;
    sys_status = 2'h2;
    walk(8'h03, 4);
    scan({28'h0, `TSM_OP_LINK_SEL}, 4, word);
    check("ir capture", word[3:0], {sys_status, `TSM_IR_CAP_LOW});
    check("instr link", instr, `TSM_OP_LINK_SEL);
    walk(8'h01, 3);
    scan(32'h2, 4, word);
    check("link capture", word[3:0], `TSM_LINK_RST);
    check("link bits", {lc, lm}, 2'h2);
    walk(8'h03, 4);
    scan({28'h0, `TSM_OP_DBG_EN}, 4, word);
    check("instr debug", instr, `TSM_OP_DBG_EN);
    walk(8'h01, 3);
    scan(32'hA, 4, word);
    check("debug scan", word[3:0], 4'hF);
    check("debug strobes", {dbg_caps[3:0], dbg_shifts[3:0], dbg_upds[3:0]}, 12'h141);
    check("debug bits", dbg_seen, 4'hA);
  endtask
  // Test reset dropped in mid data scan with the test clock parked
  task automatic t_trst;
    walk(8'h01, 3);
    probe_i.hold(5);
    check("shift oe_n", tdo_oe_n, 1'b0);
    probe_i.trst_n = 1'b0;
    #1;
    check("trst state", tap_state, 4'hF);
    check("trst instr", instr, `TSM_OP_IDCODE);
    check("trst oe_n", tdo_oe_n, 1'b1);
    check("trst link", {lc, lm}, 2'h1);
    probe_i.hold(2);
    probe_i.trst_n = 1'b1;
    probe_i.hold(3);
  endtask
  task automatic t_five;
    walk(8'h16, 6);
    check("pause ir", tap_state, 4'hB);
    probe_i.reset5();
    check("five high", tap_state, 4'hF);
  endtask
  initial begin
    nrst = 1'b0;
    sys_status = 2'h0;
    dbg_tdo = 1'b1;
    err_total = 0;
    compares = 0;
    repeat (5) @(posedge core_clk);
    #1 nrst = 1'b1;
    probe_i.hold(3);
    t_reset();
    t_arcs();
    t_idcode();
    t_link();
    t_trst();
    t_five();
    conclude();
  end
  // Whole run needs about 5 us
  initial begin
    #50000;
    err_total++;
    conclude();
  end
endmodule
`default_nettype wire
